// ===== core/tof_seq_map.vh
// tof_seq_map.vh: constants shared by the time-of-flight sequencer files
// assumes inclusion by bare name; definitions only
`ifndef TOF_SEQ_MAP_VH
`define TOF_SEQ_MAP_VH

// first fine time result, word index in the serial register map
`define FIRST_FINE_TIME_RESULT_OFS 6'h10
// second_config_reg reset value: one stop, no averaging, ten cal periods
`define SECOND_CONFIG_RESET 8'h40
// irq mask reset value: all three sources enabled
`define IRQ_MASK_RESET 3'h7
// overflow thresholds and stop window reset values
`define OVF_THRESHOLD_RESET 16'hFFFF
`define STOP_WINDOW_RESET 16'h0000

// flag positions in irq_status_reg
`define FLAG_READY 0
`define FLAG_COARSE 1
`define FLAG_CLOCK 2

// fine steps per reference period and divider of the coarse compare
`define FINE_PER_CLK 24'h0001C6
`define FINE_FRAC 24'h000001
`define COARSE_DIV 24'h00003F

// choices of second_cal_period_count
`define CAL_PERIODS_0 6'h02
`define CAL_PERIODS_1 6'h0A
`define CAL_PERIODS_2 6'h14
`define CAL_PERIODS_3 6'h28

// most stops per measurement
`define MAX_STOPS 3'h5

// host wait times after enable rises, in ns
`define PORT_READY_DELAY_NS 100000
`define REGULATOR_FULL_SETTLE_DELAY_NS 1500000

`endif

// ===== core/edge_sync.v
// edge_sync: brings an asynchronous pin into mclk and flags a chosen edge
// assumes the pin holds each level for at least two clock periods
`default_nettype none

module edge_sync (
    input wire mclk_i,
    input wire sys_rst_i,
    input wire pin_i,
    input wire falling_i,
    output reg edge_o
);
    reg meta_reg;
    reg sync_reg;
    reg prev_reg;

    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
            edge_o <= 1'b0;
        end else begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
            // the second and third stages feed the edge compare
            edge_o <= falling_i ? (prev_reg & ~sync_reg) : (~prev_reg & sync_reg);
        end
    end
endmodule

`default_nettype wire

// ===== core/tof_measurement_sequencer.v
// tof_measurement_sequencer: two independent measurement channels
// assumes register logic on mclk_i supplies config levels and one-cycle strobes;
// start, stop and enable pins are asynchronous to mclk_i, which is the reference clock
`default_nettype none
`include "tof_seq_map.vh"

// Operation
// - missing stop ends by counter overflow interrupt
// - missing start waits forever, never times out
// - time to last stop, keep earlier stops
// - stop count field selects one to five
// - averaging series runs alone, one final interrupt
// - averaging field selects 1 to 128 cycles
// - after calibration retrigger or raise interrupt
// - begin bit drives front end trigger
// - arm start after trigger, drop trigger on start
// - clock counter starts after start edge
// - stops accepted once counter reaches stop window
// - final stop starts calibration, disables pins
// - new begin bit or flag clear releases interrupt
// - repeat begin bit without enable toggle
// - enable low clears everything to defaults
// - two channels with own pins and sequences
// - coarse overflow (not in mode 2) when fine over 63 reaches threshold
// - clock overflow above threshold aborts measurement
// - calibrate after completion, skip on abort
// - fine counter covers edge to next clock
module tof_measurement_sequencer #(
    parameter CHANNELS = 2,
    parameter STOPS = 5
) (
    input wire mclk_i,
    input wire sys_rst_i,
    input wire enable_i,
    input wire [CHANNELS-1:0] start_edge_in_i,
    input wire [CHANNELS-1:0] stop_edge_in_i,
    input wire [CHANNELS-1:0] begin_measurement_bit_i,
    input wire [CHANNELS-1:0] meas_mode2_i,
    input wire [CHANNELS-1:0] start_falling_i,
    input wire [CHANNELS-1:0] stop_falling_i,
    input wire [3*CHANNELS-1:0] stop_count_i,
    input wire [3*CHANNELS-1:0] averaging_count_field_i,
    input wire [2*CHANNELS-1:0] second_cal_period_count_i,
    input wire [3*CHANNELS-1:0] irq_mask_i,
    input wire [3*CHANNELS-1:0] flag_clear_i,
    input wire [16*CHANNELS-1:0] coarse_ovf_threshold_i,
    input wire [16*CHANNELS-1:0] clock_ovf_threshold_i,
    input wire [8*CHANNELS-1:0] stop_window_high_i,
    input wire [8*CHANNELS-1:0] stop_window_low_i,
    output reg [CHANNELS-1:0] en_dummy_unused_o,
    output wire [CHANNELS-1:0] front_end_trigger_out_o,
    output wire [CHANNELS-1:0] completion_irq_n_o,
    output wire [CHANNELS-1:0] busy_o,
    output wire [CHANNELS-1:0] result_ready_flag_o,
    output wire [CHANNELS-1:0] coarse_overflow_flag_o,
    output wire [CHANNELS-1:0] clock_overflow_flag_o,
    output wire [24*(STOPS+1)*CHANNELS-1:0] fine_time_o,
    output wire [24*STOPS*CHANNELS-1:0] clock_count_o,
    output wire [24*CHANNELS-1:0] single_period_cal_result_o,
    output wire [24*CHANNELS-1:0] multi_period_cal_result_o
);
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_ARM = 4'h2;
    localparam [3:0] ST_RUN = 4'h4;
    localparam [3:0] ST_CAL = 4'h8;

    reg en_meta_reg;
    reg en_ok_reg;

    // enable acts as the digital reset; low holds every channel at defaults
    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            en_meta_reg <= 1'b0;
            en_ok_reg <= 1'b0;
            en_dummy_unused_o <= {CHANNELS{1'b0}};
        end else begin
            en_meta_reg <= enable_i;
            en_ok_reg <= en_meta_reg;
            en_dummy_unused_o <= {CHANNELS{en_ok_reg}};
        end
    end

    genvar ch;
    genvar k;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : chan
            wire start_ev;
            wire stop_ev;
            wire [2:0] avg_log = averaging_count_field_i[3*ch +: 3];
            wire [2:0] nstop_raw = stop_count_i[3*ch +: 3];
            wire [15:0] clk_thr = clock_ovf_threshold_i[16*ch +: 16];
            wire [15:0] mask_val = {stop_window_high_i[8*ch +: 8],
                                    stop_window_low_i[8*ch +: 8]};
            wire [23:0] coarse_lim;
            reg [2:0] nstop;
            reg [5:0] cal_periods;
            reg [3:0] state_reg;
            reg trig_reg;
            reg irq_n_reg;
            reg [2:0] flag_reg;
            reg [2:0] flag_next;
            reg [23:0] clk_cnt_reg;
            reg [23:0] fine_reg;
            reg [2:0] stop_idx_reg;
            reg [7:0] avg_left_reg;
            reg [5:0] cal_cnt_reg;
            reg [23:0] cal1_reg;
            reg [23:0] cal2_reg;
            reg [23:0] time_mem [0:STOPS];
            reg [23:0] cnt_mem [0:STOPS-1];
            integer i;

            edge_sync start_sync (
                .mclk_i(mclk_i),
                .sys_rst_i(sys_rst_i),
                .pin_i(start_edge_in_i[ch]),
                .falling_i(start_falling_i[ch]),
                .edge_o(start_ev)
            );
            edge_sync stop_sync (
                .mclk_i(mclk_i),
                .sys_rst_i(sys_rst_i),
                .pin_i(stop_edge_in_i[ch]),
                .falling_i(stop_falling_i[ch]),
                .edge_o(stop_ev)
            );

            // coarse count is fine count over 63, compared by scaling the threshold
            assign coarse_lim = {8'h00, coarse_ovf_threshold_i[16*ch +: 16]} * `COARSE_DIV;

            always @* begin
                // out-of-range stop counts are clamped rather than refused
                if (nstop_raw == 3'h0)
                    nstop = 3'h1;
                else if (nstop_raw > `MAX_STOPS)
                    nstop = `MAX_STOPS;
                else
                    nstop = nstop_raw;
                case (second_cal_period_count_i[2*ch +: 2])
                    2'h0: cal_periods = `CAL_PERIODS_0;
                    2'h1: cal_periods = `CAL_PERIODS_1;
                    2'h2: cal_periods = `CAL_PERIODS_2;
                    default: cal_periods = `CAL_PERIODS_3;
                endcase
                // flag sets live here so the clocked block keeps to non-blocking updates
                flag_next = flag_reg & ~flag_clear_i[3*ch +: 3];
                case (state_reg)
                    ST_RUN: begin
                        // clock overflow is tested first, so one abort sets one flag
                        if (clk_cnt_reg > {8'h00, clk_thr})
                            flag_next[`FLAG_CLOCK] = 1'b1;
                        else if (!meas_mode2_i[ch] && fine_reg >= coarse_lim)
                            flag_next[`FLAG_COARSE] = 1'b1;
                    end
                    ST_CAL: begin
                        // the ready flag waits for the last cycle of an averaging series
                        if (cal_cnt_reg + 6'h01 == cal_periods && avg_left_reg == 8'h00)
                            flag_next[`FLAG_READY] = 1'b1;
                    end
                    default: begin
                    end
                endcase
            end

            always @(posedge mclk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    state_reg <= ST_IDLE;
                    trig_reg <= 1'b0;
                    irq_n_reg <= 1'b1;
                    flag_reg <= 3'h0;
                    clk_cnt_reg <= 24'h000000;
                    fine_reg <= 24'h000000;
                    stop_idx_reg <= 3'h0;
                    avg_left_reg <= 8'h00;
                    cal_cnt_reg <= 6'h00;
                    cal1_reg <= 24'h000000;
                    cal2_reg <= 24'h000000;
                    for (i = 0; i <= STOPS; i = i + 1)
                        time_mem[i] <= 24'h000000;
                    for (i = 0; i < STOPS; i = i + 1)
                        cnt_mem[i] <= 24'h000000;
                end else if (!en_ok_reg) begin
                    state_reg <= ST_IDLE;
                    trig_reg <= 1'b0;
                    irq_n_reg <= 1'b1;
                    flag_reg <= 3'h0;
                    clk_cnt_reg <= 24'h000000;
                    fine_reg <= 24'h000000;
                    stop_idx_reg <= 3'h0;
                    avg_left_reg <= 8'h00;
                    cal_cnt_reg <= 6'h00;
                    cal1_reg <= 24'h000000;
                    cal2_reg <= 24'h000000;
                    for (i = 0; i <= STOPS; i = i + 1)
                        time_mem[i] <= 24'h000000;
                    for (i = 0; i < STOPS; i = i + 1)
                        cnt_mem[i] <= 24'h000000;
                end else if (begin_measurement_bit_i[ch]) begin
                    // a new begin restarts from any state, no enable toggle needed
                    state_reg <= ST_ARM;
                    trig_reg <= 1'b1;
                    flag_reg <= 3'h0;
                    irq_n_reg <= 1'b1;
                    avg_left_reg <= 8'hFF >> (4'h8 - {1'b0, avg_log});
                    stop_idx_reg <= 3'h0;
                    cal1_reg <= 24'h000000;
                    cal2_reg <= 24'h000000;
                    for (i = 0; i <= STOPS; i = i + 1)
                        time_mem[i] <= 24'h000000;
                    for (i = 0; i < STOPS; i = i + 1)
                        cnt_mem[i] <= 24'h000000;
                end else begin
                    case (state_reg)
                        ST_IDLE: begin
                            trig_reg <= 1'b0;
                        end
                        ST_ARM: begin
                            // no timeout here: a missing start leaves the channel armed
                            if (start_ev) begin
                                trig_reg <= 1'b0;
                                // both counters include the period from start to the first edge
                                clk_cnt_reg <= 24'h000001;
                                fine_reg <= `FINE_PER_CLK;
                                stop_idx_reg <= 3'h0;
                                if (meas_mode2_i[ch])
                                    time_mem[0] <= time_mem[0] + `FINE_FRAC;
                                state_reg <= ST_RUN;
                            end
                        end
                        ST_RUN: begin
                            clk_cnt_reg <= clk_cnt_reg + 24'h000001;
                            fine_reg <= fine_reg + `FINE_PER_CLK;
                            if (clk_cnt_reg > {8'h00, clk_thr}) begin
                                state_reg <= ST_IDLE;
                            end else if (!meas_mode2_i[ch] && fine_reg >= coarse_lim) begin
                                state_reg <= ST_IDLE;
                            end else if (stop_ev && clk_cnt_reg >= {8'h00, mask_val}) begin
                                if (meas_mode2_i[ch]) begin
                                    time_mem[stop_idx_reg + 3'h1] <=
                                        time_mem[stop_idx_reg + 3'h1] + `FINE_FRAC;
                                    cnt_mem[stop_idx_reg] <= cnt_mem[stop_idx_reg] + clk_cnt_reg;
                                end else begin
                                    time_mem[stop_idx_reg] <= time_mem[stop_idx_reg] + fine_reg;
                                end
                                if (stop_idx_reg + 3'h1 == nstop) begin
                                    cal_cnt_reg <= 6'h00;
                                    state_reg <= ST_CAL;
                                end else begin
                                    stop_idx_reg <= stop_idx_reg + 3'h1;
                                end
                            end
                        end
                        ST_CAL: begin
                            // calibration only after a completed measurement
                            cal_cnt_reg <= cal_cnt_reg + 6'h01;
                            cal2_reg <= cal2_reg + `FINE_PER_CLK;
                            if (cal_cnt_reg + 6'h01 == cal_periods) begin
                                cal1_reg <= cal1_reg + `FINE_PER_CLK;
                                if (avg_left_reg == 8'h00) begin
                                    state_reg <= ST_IDLE;
                                end else begin
                                    avg_left_reg <= avg_left_reg - 8'h01;
                                    trig_reg <= 1'b1;
                                    stop_idx_reg <= 3'h0;
                                    state_reg <= ST_ARM;
                                end
                            end
                        end
                        default: begin
                            state_reg <= ST_IDLE;
                            trig_reg <= 1'b0;
                        end
                    endcase
                    flag_reg <= flag_next;
                    irq_n_reg <= ~|(flag_next & irq_mask_i[3*ch +: 3]);
                end
            end

            assign front_end_trigger_out_o[ch] = trig_reg;
            assign completion_irq_n_o[ch] = irq_n_reg;
            assign busy_o[ch] = ~state_reg[0];
            assign result_ready_flag_o[ch] = flag_reg[`FLAG_READY];
            assign coarse_overflow_flag_o[ch] = flag_reg[`FLAG_COARSE];
            assign clock_overflow_flag_o[ch] = flag_reg[`FLAG_CLOCK];
            assign single_period_cal_result_o[24*ch +: 24] = cal1_reg;
            assign multi_period_cal_result_o[24*ch +: 24] = cal2_reg;
            for (k = 0; k <= STOPS; k = k + 1) begin : tmap
                assign fine_time_o[24*((STOPS+1)*ch+k) +: 24] = time_mem[k];
            end
            for (k = 0; k < STOPS; k = k + 1) begin : cmap
                assign clock_count_o[24*(STOPS*ch+k) +: 24] = cnt_mem[k];
            end
        end
    endgenerate
endmodule

`default_nettype wire

// ===== verification/tof_seq_properties.sv
// tof_seq_properties: timing checks on the sequencer's channel ports
// assumes one mclk_i domain and sys_rst_i high while in reset
`default_nettype none
module tof_seq_checker #(
    parameter CHANNELS = 2,
    parameter STOPS = 5
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic enable_i,
    input wire logic [CHANNELS-1:0] start_edge_in_i,
    input wire logic [CHANNELS-1:0] begin_measurement_bit_i,
    input wire logic [3*CHANNELS-1:0] flag_clear_i,
    input wire logic [CHANNELS-1:0] en_dummy_unused_o,
    input wire logic [CHANNELS-1:0] front_end_trigger_out_o,
    input wire logic [CHANNELS-1:0] completion_irq_n_o,
    input wire logic [CHANNELS-1:0] busy_o,
    input wire logic [CHANNELS-1:0] result_ready_flag_o,
    input wire logic [CHANNELS-1:0] coarse_overflow_flag_o,
    input wire logic [CHANNELS-1:0] clock_overflow_flag_o,
    input wire logic [24*CHANNELS-1:0] multi_period_cal_result_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);
    a_trig_begin: assert property (
        begin_measurement_bit_i[0] && en_dummy_unused_o[0] |=> front_end_trigger_out_o[0])
        else $error("no trigger after begin");
    a_trig_other: assert property (
        begin_measurement_bit_i[1] && en_dummy_unused_o[1] |=> front_end_trigger_out_o[1])
        else $error("no trigger on second channel");
    a_begin_irq_high: assert property (
        begin_measurement_bit_i[0] && en_dummy_unused_o[0] |=> completion_irq_n_o[0])
        else $error("irq not released by begin");
    a_trig_busy: assert property (
        front_end_trigger_out_o[0] |-> busy_o[0])
        else $error("trigger while idle");
    a_start_drops_trig: assert property (
        $rose(start_edge_in_i[0]) && front_end_trigger_out_o[0]
            |-> ##[1:6] !front_end_trigger_out_o[0])
        else $error("trigger held after start");
    a_irq_cause: assert property (
        $fell(completion_irq_n_o[0]) |-> !busy_o[0] && !front_end_trigger_out_o[0]
            && (result_ready_flag_o[0] || coarse_overflow_flag_o[0] || clock_overflow_flag_o[0]))
        else $error("irq low without finished run");
    a_flag_clear: assert property (
        flag_clear_i[0] && !busy_o[0] |=> !result_ready_flag_o[0])
        else $error("ready flag not cleared");
    a_irq_release: assert property (
        flag_clear_i[2:0] == 3'h7 && !busy_o[0] |=> completion_irq_n_o[0])
        else $error("irq not released by clear");
    a_ovf_no_cal: assert property (
        $rose(clock_overflow_flag_o[0]) || $rose(coarse_overflow_flag_o[0])
            |-> !busy_o[0] && multi_period_cal_result_o[23:0] == 24'h000000)
        else $error("overflow did not abort");
    a_enable_clears: assert property (
        !enable_i [*5] |-> completion_irq_n_o[0] && !busy_o[0] && !result_ready_flag_o[0])
        else $error("enable low did not clear");
endmodule
bind tof_measurement_sequencer tof_seq_checker #(.CHANNELS(CHANNELS), .STOPS(STOPS)) props_inst (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .enable_i(enable_i),
    .start_edge_in_i(start_edge_in_i), .begin_measurement_bit_i(begin_measurement_bit_i),
    .flag_clear_i(flag_clear_i), .en_dummy_unused_o(en_dummy_unused_o),
    .front_end_trigger_out_o(front_end_trigger_out_o), .completion_irq_n_o(completion_irq_n_o),
    .busy_o(busy_o), .result_ready_flag_o(result_ready_flag_o),
    .coarse_overflow_flag_o(coarse_overflow_flag_o), .clock_overflow_flag_o(clock_overflow_flag_o),
    .multi_period_cal_result_o(multi_period_cal_result_o));
`default_nettype wire

// ===== verification/front_end_model.sv
// front_end_model: analog front end answering each trigger with start and stop pulses
// assumes pins change on falling mclk_i; pulses last three cycles, clear of sync limits
`default_nettype none
module front_end_model (
    input wire logic mclk_i,
    input wire logic trig_i,
    input wire logic go_i,
    input wire logic [7:0] start_dly_i,
    input wire logic [2:0] nstop_i,
    input wire logic [7:0] gap_i,
    output logic start_o,
    output logic stop_o,
    output logic [7:0] trig_cnt_o
);
    initial begin
        start_o = 0;
        stop_o = 0;
        trig_cnt_o = 0;
        forever begin
            @(negedge mclk_i);
            wait (trig_i);
            trig_cnt_o++;
            // go low models a front end that never answers
            if (!go_i) wait (!trig_i);
            else begin
                repeat (start_dly_i) @(negedge mclk_i);
                start_o = 1;
                repeat (3) @(negedge mclk_i);
                start_o = 0;
                for (int k = 0; k < nstop_i; k++) begin
                    repeat (gap_i) @(negedge mclk_i);
                    stop_o = 1;
                    repeat (3) @(negedge mclk_i);
                    stop_o = 0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== verification/tof_measurement_sequencer_test.sv
// tof_measurement_sequencer_test: self-checking bench with two front end models
// assumes the sequencer core, the checker bind and the front end model are compiled first
`default_nettype none
module tof_measurement_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 0;
    logic sys_rst_i = 1;
    logic enable_i = 0;
    logic [1:0] begin_w = 2'h0;
    logic [1:0] mode2_w = 2'h3;
    logic [1:0] go = 2'h3;
    logic [5:0] nstop_w = 6'h09;
    logic [5:0] avg_w = 6'h00;
    logic [5:0] clr_w = 6'h00;
    logic [31:0] covf_w = 32'hFFFFFFFF;
    logic [31:0] kovf_w = 32'hFFFFFFFF;
    logic [31:0] win_w = 32'h00000000;
    logic [5:0] mask_w = 6'h3F;
    logic [7:0] sdly [2];
    logic [7:0] gap [2];
    logic [2:0] mst [2];
    wire [7:0] tcnt [2];
    wire [1:0] st_w, sp_w, trig_o, irq_n_o, busy_o, rdy_o, cov_o, kov_o;
    wire [1:0] en_o;
    wire [239:0] cnt_o;
    wire [287:0] fine_o;
    wire [47:0] cal1_o, cal2_o;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    // calibration and mask tied: ten periods keep retrigger clear of the model's last pulse
    tof_measurement_sequencer #(.CHANNELS(2), .STOPS(5)) tof_measurement_sequencer_inst (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .enable_i(enable_i),
        .start_edge_in_i(st_w), .stop_edge_in_i(sp_w), .begin_measurement_bit_i(begin_w),
        .meas_mode2_i(mode2_w), .start_falling_i(2'h0), .stop_falling_i(2'h0),
        .stop_count_i(nstop_w), .averaging_count_field_i(avg_w),
        .second_cal_period_count_i(4'h5), .irq_mask_i(mask_w), .flag_clear_i(clr_w),
        .coarse_ovf_threshold_i(covf_w), .clock_ovf_threshold_i(kovf_w),
        .stop_window_high_i({win_w[31:24], win_w[15:8]}),
        .stop_window_low_i({win_w[23:16], win_w[7:0]}), .en_dummy_unused_o(en_o),
        .front_end_trigger_out_o(trig_o), .completion_irq_n_o(irq_n_o), .busy_o(busy_o),
        .result_ready_flag_o(rdy_o), .coarse_overflow_flag_o(cov_o),
        .clock_overflow_flag_o(kov_o), .fine_time_o(fine_o), .clock_count_o(cnt_o),
        .single_period_cal_result_o(cal1_o), .multi_period_cal_result_o(cal2_o));
    front_end_model fe0_inst (.mclk_i(mclk_i), .trig_i(trig_o[0]), .go_i(go[0]),
        .start_dly_i(sdly[0]), .nstop_i(mst[0]), .gap_i(gap[0]), .start_o(st_w[0]),
        .stop_o(sp_w[0]), .trig_cnt_o(tcnt[0]));
    front_end_model fe1_inst (.mclk_i(mclk_i), .trig_i(trig_o[1]), .go_i(go[1]),
        .start_dly_i(sdly[1]), .nstop_i(mst[1]), .gap_i(gap[1]), .start_o(st_w[1]),
        .stop_o(sp_w[1]), .trig_cnt_o(tcnt[1]));
    always #12.5 mclk_i = ~mclk_i;
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 70000) begin
            error_cnt++;
            $display("mismatch run length expected finish seen hang");
            end_of_test();
        end
    end
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // flight time in ns from the result words, ten calibration periods of 25 ns
    function automatic longint tof_ns(input longint t1, tn, cnt, c1, c2);
        return ((t1 - tn) * 25 * (10 - 1)) / (c2 - c1) + cnt * 25;
    endfunction
    task automatic pulse_begin(input int ch);
        @(negedge mclk_i);
        begin_w[ch] = 1;
        @(negedge mclk_i);
        begin_w[ch] = 0;
    endtask
    task automatic wait_irq(input int ch);
        int n;
        n = 0;
        while (irq_n_o[ch] !== 1'b0 && n < 20000) begin
            @(negedge mclk_i);
            n++;
        end
        chk("irq_n", 0, irq_n_o[ch]);
    endtask
    task automatic clear_all(input int ch);
        @(negedge mclk_i);
        clr_w[3*ch+:3] = 3'h7;
        @(negedge mclk_i);
        clr_w[3*ch+:3] = 3'h0;
        @(negedge mclk_i);
        chk("flags cleared", 4'h1, {kov_o[ch], cov_o[ch], rdy_o[ch], irq_n_o[ch]});
    endtask
    task automatic meas(input int ch, input logic [2:0] n, input logic [2:0] m,
            input logic [7:0] g, input logic [15:0] w, input logic [2:0] a);
        logic [7:0] t0;
        @(negedge mclk_i);
        nstop_w[3*ch+:3] = n;
        avg_w[3*ch+:3] = a;
        win_w[16*ch+:16] = w;
        mst[ch] = m;
        gap[ch] = g;
        sdly[ch] = 8'($urandom_range(12, 2));
        t0 = tcnt[ch];
        pulse_begin(ch);
        wait_irq(ch);
        chk("trigger count", 24'(1 << a), 24'(tcnt[ch] - t0));
    endtask
    task automatic slots(input int ch, input int n);
        for (int k = 0; k < 5; k++)
            chk("stop slot", 24'(k < n), 24'(cnt_o[24*(5*ch+k)+:24] != 0));
    endtask
    initial begin
        void'($urandom(54220));
        repeat (4) @(negedge mclk_i);
        sys_rst_i = 0;
        enable_i = 1;
        repeat (4) @(negedge mclk_i);
        chk("irq_n after reset", 2'h3, irq_n_o);
        chk("enable seen", 2'h3, en_o);
        repeat (60000) @(negedge mclk_i);
        for (int i = 0; i < 4; i++) begin
            int ch;
            int n;
            int g;
            longint t;
            ch = $urandom_range(1, 0);
            n = $urandom_range(5, 1);
            g = $urandom_range(20, 4);
            meas(ch, n, n, 8'(g), 16'h0000, 3'h0);
            t = tof_ns(fine_o[144*ch+:24], fine_o[144*ch+24+:24], cnt_o[120*ch+:24],
                cal1_o[24*ch+:24], cal2_o[24*ch+:24]);
            chk("flight time", 24'((3 + g) * 25), 24'(t));
            chk("ready flag", 1, rdy_o[ch]);
            chk("cal ran", 1, cal2_o[24*ch+:24] != 0);
            chk("other irq_n", 1, irq_n_o[1-ch]);
            slots(ch, n);
            clear_all(ch);
            $display("test random stops %0d channel %0d done", n, ch);
        end
        // first stop falls inside the window, second lands after it
        meas(0, 3'h1, 3'h2, 8'h0C, 16'h0014, 3'h0);
        chk("masked count", 24'h00001E, cnt_o[23:0]);
        slots(0, 1);
        clear_all(0);
        $display("test stop window done");
        meas(0, 3'h1, 3'h1, 8'h06, 16'h0000, 3'h2);
        chk("ready after series", 1, rdy_o[0]);
        chk("averaged count", 24'h000009, cnt_o[23:0] >> 2);
        clear_all(0);
        $display("test averaging done");
        kovf_w[15:0] = 16'h0028;
        meas(0, 3'h1, 3'h0, 8'h04, 16'h0000, 3'h0);
        chk("clock overflow", 3'h4, {kov_o[0], cov_o[0], rdy_o[0]});
        chk("cal on abort", 0, cal2_o[23:0]);
        clear_all(0);
        kovf_w[15:0] = 16'hFFFF;
        mode2_w[0] = 0;
        covf_w[15:0] = 16'h0002;
        meas(0, 3'h1, 3'h0, 8'h04, 16'h0000, 3'h0);
        chk("coarse overflow", 3'h2, {kov_o[0], cov_o[0], rdy_o[0]});
        clear_all(0);
        mode2_w[0] = 1;
        covf_w[15:0] = 16'hFFFF;
        $display("test overflows done");
        go[0] = 0;
        pulse_begin(0);
        repeat (400) @(negedge mclk_i);
        chk("waiting for start", 3'h7, {busy_o[0], trig_o[0], irq_n_o[0]});
        enable_i = 0;
        repeat (8) @(negedge mclk_i);
        chk("disabled", 4'h1, {en_o[0], busy_o[0], trig_o[0], irq_n_o[0]});
        enable_i = 1;
        go[0] = 1;
        repeat (4) @(negedge mclk_i);
        $display("test missing start and enable done");
        end_of_test();
    end
endmodule
`default_nettype wire
